// ==== common/rbms_regs.vh ====
/*
 * Constants of the reset and boot-mode select block: register offsets,
 * field positions, reset values, mode pin codes and timing counts.
 * Assumes inclusion by bare name from design files under core/.
 */
`ifndef RBMS_REGS_VH
`define RBMS_REGS_VH

// Register offsets (4-bit word address)
`define RBMS_ADDR_W 4
`define RBMS_DATA_W 16
`define RBMS_OFF_AUTOBUF_CTL 4'h0
`define RBMS_OFF_MODE_STATUS 4'h1
`define RBMS_OFF_INT_MASK 4'h2
`define RBMS_OFF_STATUS 4'h3
`define RBMS_OFF_FLAG_DIR 4'h4
`define RBMS_OFF_FLAG_DATA 4'h5

// Field positions
`define RBMS_CLK_OUT_DIS_BIT 14
`define RBMS_MODE_STAT_W 7
`define RBMS_IMASK_W 10
`define RBMS_ST_MODE_A 0
`define RBMS_ST_MODE_B 1
`define RBMS_ST_MODE_C 2
`define RBMS_ST_MODE_D 3
`define RBMS_ST_HOST 4
`define RBMS_ST_STABLE 5
`define RBMS_ST_HOLD 6
`define RBMS_ST_STACK_EMPTY 7
`define RBMS_ST_STATE_LSB 8

// Reset values
`define RBMS_RST_AUTOBUF_CTL 16'h0000
`define RBMS_RST_MODE_STATUS 7'h00
`define RBMS_RST_INT_MASK 10'h000
`define RBMS_RST_FLAG_DIR 1'b0
`define RBMS_RST_FLAG_DATA 1'b0

// Boot kinds decoded from mode pins
`define RBMS_BOOT_NONE 2'h0
`define RBMS_BOOT_BYTE 2'h1
`define RBMS_BOOT_HOST 2'h2

// Timing: input clock runs at half the cycle rate
`define RBMS_INCLK_DIV 2
`define RBMS_PLL_LOCK_INCLK 2000
`define RBMS_LOCK_CNT_W 11
`define RBMS_BOOT_WORDS 6'h20
`define RBMS_FIRST_FETCH 14'h0000

`endif

// ==== core/rbms_clk_gen.v ====
/*
 * Clock output at half the cycle rate (toggles every mclk) and input-clock-rate enable.
 * Assumes mclk is the processor cycle clock, twice the input clock rate.
 */
`timescale 1ns/100ps
`include "rbms_regs.vh"
module rbms_clk_gen (
    input wire mclk,
    input wire rst,
    input wire clkOutDisable,
    output reg inClkEn_r,
    output reg cycleClkOut_r
);
    // Derived enable instead of a second clock
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            inClkEn_r <= 1'b0;
            cycleClkOut_r <= 1'b0;
        end else begin
            inClkEn_r <= ~inClkEn_r;
            // Half-period of cycle clock per mclk; held low when switched off
            cycleClkOut_r <= clkOutDisable ? 1'b0 : ~cycleClkOut_r;
        end
    end
endmodule

// ==== core/rbms_core.v ====
/*
 * Reset sequencing, mode strap capture and boot selection.
 * Assumes all pins synchronous to mclk; rst is the power-on reset,
 * resetN the board master reset.
 */
// The address map and the strobed register port were chosen for this implementation.
// Contract
// R1: Cycle clock runs twice the input clock
// R2: Partner never stops input clock outside power-down
// R3: Cycle clock output gated by disable bit
// R4: Partner holds reset through 2000 input clocks
// R5: Later resets need no new stabilisation
// R6: Master reset empties stacks, masks, clears status
// R7: Boot only without bus request, booting mode
// R8: First fetch at internal address zero
// R9: Memory mode pin sampled in reset, flag after
// R10: Modes 000: full memory, byte boot 32
// R11: Mode 010: no boot, external address zero
// R12: Mode 100: host mode, byte boot 32
// R13: Mode 101: host mode, wait host write 0
// R14: Ack drive pin 0: acknowledge actively driven
// R15: Ack drive pin 1: acknowledge open drain
// R16: Partner releases strap driver after reset
// R17: Resistor strap: flag input in power-down
// R18: Buffer strap: flag output in power-down
// R19: Straps latched at reset release, held
`timescale 1ns/100ps
`include "rbms_regs.vh"
module rbms_core (
    input wire mclk,
    input wire rst,
    input wire resetN,
    input wire modeA,
    input wire modeB,
    input wire modeD,
    input wire flagTwoIn,
    output reg flagTwoOut_r,
    output wire flagTwoOeN,
    input wire busReq,
    input wire byteDmaWordDone,
    input wire hostPmWrite,
    input wire [13:0] hostPmAddr,
    input wire ackReq,
    output reg hostAckOut,
    output reg hostAckOeN,
    output reg byteDmaStart_r,
    output wire [5:0] byteDmaWords,
    output reg coreHold_r,
    output reg fetchExternal_r,
    output reg [13:0] firstFetchAddr_r,
    output reg hostMode_r,
    output reg masterReset_r,
    output wire cycleClockOut,
    input wire [3:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdata_r
);
    // Sequencer states
    localparam ST_RESET = 3'h0;
    localparam ST_LOCK = 3'h1;
    localparam ST_CHECK = 3'h2;
    localparam ST_BYTE_BOOT = 3'h3;
    localparam ST_HOST_BOOT = 3'h4;
    localparam ST_RUN = 3'h5;

    // Boot kind from memory-mode, boot-disable and boot-source pins
    function [1:0] bootKind;
        input c;
        input b;
        input a;
        begin
            case ({c, b, a})
                3'b000: bootKind = `RBMS_BOOT_BYTE;
                3'b100: bootKind = `RBMS_BOOT_BYTE;
                3'b101: bootKind = `RBMS_BOOT_HOST;
                default: bootKind = `RBMS_BOOT_NONE;
            endcase
        end
    endfunction

    // Register address match
    function hit;
        input [3:0] addr;
        input [3:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [15:0] autobufCtl_r;
    reg [6:0] modeStatus_r;
    reg [9:0] intMask_r;
    reg flagDir_r;
    reg stackEmpty_r;
    reg resetNPrev_r;
    // Strap order: D, C, B, A from bit 3 down
    reg [3:0] strapShadow_r;
    reg [3:0] strapCfg_r;
    reg [1:0] bootKind_r;
    reg [`RBMS_LOCK_CNT_W-1:0] lockCnt_r;
    reg locked_r;
    reg [5:0] wordCnt_r;
    wire inClkEn;
    wire clkOutDisable;
    wire releaseEdge;
    wire bootDone;
    wire byteBootDone;
    wire hostBootDone;
    wire [15:0] statusWord;

    assign clkOutDisable = autobufCtl_r[`RBMS_CLK_OUT_DIS_BIT];
    assign releaseEdge = resetN & ~resetNPrev_r;
    assign byteDmaWords = `RBMS_BOOT_WORDS;

    rbms_clk_gen i_rbms_clk_gen (
        .mclk(mclk),
        .rst(rst),
        .clkOutDisable(clkOutDisable),
        .inClkEn_r(inClkEn),
        .cycleClkOut_r(cycleClockOut) // R1 R3
    );

    // Lock wait counts input-clock periods once after power-on only
    // Later master resets skip it: the input clock never stops
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            lockCnt_r <= {`RBMS_LOCK_CNT_W{1'b0}};
            locked_r <= 1'b0;
        end else if (!locked_r && inClkEn) begin
            if (lockCnt_r == `RBMS_PLL_LOCK_INCLK - 1) begin
                locked_r <= 1'b1; // R4
            end
            lockCnt_r <= lockCnt_r + 1'b1;
        end
    end

    // Strap capture: shadow follows pins in reset, frozen on release
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            resetNPrev_r <= 1'b0;
            strapShadow_r <= 4'h0;
            strapCfg_r <= 4'h0;
            bootKind_r <= `RBMS_BOOT_NONE;
            hostMode_r <= 1'b0;
        end else begin
            resetNPrev_r <= resetN;
            if (!resetN) begin
                strapShadow_r <= {modeD, flagTwoIn, modeB, modeA}; // R9
            end
            if (releaseEdge) begin
                strapCfg_r <= strapShadow_r; // R19
                bootKind_r <= bootKind(strapShadow_r[2], strapShadow_r[1], strapShadow_r[0]);
                hostMode_r <= strapShadow_r[2]; // R10 R12
            end
        end
    end

    // Byte boot ends on the pulse that carries the last word
    assign byteBootDone = (state_r == ST_BYTE_BOOT)
                          && byteDmaWordDone
                          && (wordCnt_r == `RBMS_BOOT_WORDS - 6'h01);
    // Host boot ends only on a write to the first fetch address
    assign hostBootDone = (state_r == ST_HOST_BOOT)
                          && hostPmWrite
                          && (hostPmAddr == `RBMS_FIRST_FETCH);
    assign bootDone = byteBootDone | hostBootDone;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: begin
                if (resetN) begin
                    state_nxt = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (locked_r) begin // R5
                    state_nxt = ST_CHECK;
                end
            end
            ST_CHECK: begin
                // A pending bus request defers the decision
                if (!busReq) begin // R7
                    case (bootKind_r)
                        `RBMS_BOOT_BYTE: state_nxt = ST_BYTE_BOOT; // R10 R12
                        `RBMS_BOOT_HOST: state_nxt = ST_HOST_BOOT; // R13
                        default: state_nxt = ST_RUN; // R11
                    endcase
                end
            end
            ST_BYTE_BOOT: begin
                if (bootDone) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_HOST_BOOT: begin
                if (bootDone) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: state_nxt = ST_RUN;
            default: state_nxt = ST_RESET;
        endcase
        if (!resetN) begin
            state_nxt = ST_RESET;
        end
    end

    // Hold drops with the edge that enters the run state
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_RESET;
            wordCnt_r <= 6'h00;
            byteDmaStart_r <= 1'b0;
            coreHold_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            byteDmaStart_r <= (state_r == ST_CHECK) && (state_nxt == ST_BYTE_BOOT);
            if (state_r != ST_BYTE_BOOT) begin
                wordCnt_r <= 6'h00;
            end else if (byteDmaWordDone) begin
                wordCnt_r <= wordCnt_r + 6'h01; // R10 R12
            end
            // Execution held until the boot sequence ends
            coreHold_r <= (state_nxt != ST_RUN); // R10 R12 R13
        end
    end

    // First fetch source: external memory only when boot is skipped
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            fetchExternal_r <= 1'b0;
            firstFetchAddr_r <= `RBMS_FIRST_FETCH;
        end else begin
            if (state_r == ST_CHECK && state_nxt == ST_RUN) begin
                fetchExternal_r <= 1'b1; // R11
            end else if (state_nxt != ST_RUN) begin
                fetchExternal_r <= 1'b0;
            end
            firstFetchAddr_r <= `RBMS_FIRST_FETCH; // R8 R11
        end
    end

    // Master reset clears core state while the pin is low
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            masterReset_r <= 1'b1;
            stackEmpty_r <= 1'b1;
        end else if (!resetN) begin
            masterReset_r <= 1'b1;
            stackEmpty_r <= 1'b1; // R6
        end else begin
            masterReset_r <= 1'b0;
            // Stacks leave empty once the core runs
            if (state_r == ST_RUN) begin
                stackEmpty_r <= 1'b0;
            end
        end
    end

    // Software registers; writes in reset are dropped so reset values win
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            modeStatus_r <= `RBMS_RST_MODE_STATUS;
            intMask_r <= `RBMS_RST_INT_MASK;
            autobufCtl_r <= `RBMS_RST_AUTOBUF_CTL;
            flagDir_r <= `RBMS_RST_FLAG_DIR;
            flagTwoOut_r <= `RBMS_RST_FLAG_DATA;
        end else if (!resetN) begin
            modeStatus_r <= `RBMS_RST_MODE_STATUS; // R6
            intMask_r <= `RBMS_RST_INT_MASK; // R6
            autobufCtl_r <= `RBMS_RST_AUTOBUF_CTL;
            flagDir_r <= `RBMS_RST_FLAG_DIR; // R9
            flagTwoOut_r <= `RBMS_RST_FLAG_DATA;
        end else if (regWr) begin
            if (hit(regAddr, `RBMS_OFF_AUTOBUF_CTL)) begin
                autobufCtl_r <= regWdata; // R3
            end
            if (hit(regAddr, `RBMS_OFF_MODE_STATUS)) begin
                modeStatus_r <= regWdata[`RBMS_MODE_STAT_W-1:0];
            end
            if (hit(regAddr, `RBMS_OFF_INT_MASK)) begin
                intMask_r <= regWdata[`RBMS_IMASK_W-1:0];
            end
            if (hit(regAddr, `RBMS_OFF_FLAG_DIR)) begin
                flagDir_r <= regWdata[0]; // R17 R18
            end
            if (hit(regAddr, `RBMS_OFF_FLAG_DATA)) begin
                flagTwoOut_r <= regWdata[0];
            end
        end
    end

    // Pin stays released through reset so the strap can be read
    assign flagTwoOeN = ~(flagDir_r & resetN); // R9 R16

    // Acknowledge pin drive style chosen by latched strap
    always @* begin
        hostAckOut = 1'b1;
        hostAckOeN = 1'b1;
        if (hostMode_r && resetN) begin
            if (!strapCfg_r[3]) begin
                hostAckOut = ~ackReq; // R14
                hostAckOeN = 1'b0;
            end else begin
                // Board pull-down shows acknowledge; we only drive high
                hostAckOut = 1'b1;
                hostAckOeN = ackReq; // R15
            end
        end
    end

    // Read-only view of sequencer state and the latched straps
    assign statusWord = {5'h00,
                         state_r,
                         stackEmpty_r,
                         coreHold_r,
                         locked_r,
                         hostMode_r,
                         strapCfg_r};

    // Read data stand one cycle, then return to zero
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdata_r <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `RBMS_OFF_AUTOBUF_CTL: regRdata_r <= autobufCtl_r;
                `RBMS_OFF_MODE_STATUS: regRdata_r <= {9'h000, modeStatus_r};
                `RBMS_OFF_INT_MASK: regRdata_r <= {6'h00, intMask_r};
                `RBMS_OFF_STATUS: regRdata_r <= statusWord;
                `RBMS_OFF_FLAG_DIR: regRdata_r <= {15'h0000, flagDir_r};
                `RBMS_OFF_FLAG_DATA: regRdata_r <= {15'h0000, flagTwoIn};
                default: regRdata_r <= 16'h0000;
            endcase
        end else begin
            regRdata_r <= 16'h0000;
        end
    end
endmodule

// ==== dv/rbms_core_monitor.sv ====
/* Port checker for rbms_core.
   Assumes one mclk domain; bound to every rbms_core instance. */
`timescale 1ns/100ps
module rbms_core_monitor (
    input logic mclk,
    input logic rst,
    input logic resetN,
    input logic modeA,
    input logic modeB,
    input logic modeD,
    input logic flagTwoOeN,
    input logic ackReq,
    input logic hostAckOut,
    input logic hostAckOeN,
    input logic byteDmaStart_r,
    input logic coreHold_r,
    input logic hostMode_r,
    input logic masterReset_r,
    input logic cycleClockOut,
    input logic hostPmWrite,
    input logic [13:0] hostPmAddr,
    input logic [13:0] firstFetchAddr_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Latched straps are trusted only well after release
    sequence s_settled;
        resetN && $past(resetN, 3);
    endsequence
    sequence s_hostLoad;
        coreHold_r && hostMode_r && modeA && !modeB && hostPmWrite && hostPmAddr == 14'h0000;
    endsequence
    AST_PIN_FREE: assert property (!resetN |-> flagTwoOeN) else $error("pin driven in reset");
    AST_MRST: assert property (!resetN |=> masterReset_r) else $error("no master reset");
    AST_MRST_END: assert property ($rose(resetN) |-> ##[1:2] !masterReset_r)
        else $error("master reset stuck");
    AST_FETCH: assert property (firstFetchAddr_r == 14'h0000) else $error("fetch addr");
    AST_ACK_DRV: assert property (s_settled ##0 (hostMode_r && !modeD) |->
        !hostAckOeN && hostAckOut == !ackReq) else $error("ack not driven");
    AST_ACK_OD: assert property (s_settled ##0 (hostMode_r && modeD) |->
        hostAckOut && hostAckOeN == ackReq) else $error("ack not open drain");
    AST_ACK_FULL: assert property (s_settled ##0 !hostMode_r |-> hostAckOeN)
        else $error("ack driven in full mode");
    AST_START: assert property ($rose(byteDmaStart_r) |-> coreHold_r ##1 !byteDmaStart_r)
        else $error("start pulse");
    AST_HOST_LOAD: assert property (s_settled ##0 s_hostLoad |-> ##[1:2] !coreHold_r)
        else $error("hold after host write");
    AST_CLK_OUT: assert property (cycleClockOut |=> !cycleClockOut) else $error("clock out");
endmodule

bind rbms_core rbms_core_monitor i_rbms_core_monitor (.mclk, .rst, .resetN, .modeA, .modeB,
    .modeD, .flagTwoOeN, .ackReq, .hostAckOut, .hostAckOeN, .byteDmaStart_r, .coreHold_r,
    .hostMode_r, .masterReset_r, .cycleClockOut, .hostPmWrite, .hostPmAddr, .firstFetchAddr_r);

// ==== dv/rbms_strap_model.sv ====
/* Board reset source and strap circuitry.
   Assumes strap = {D,C,B,A} has D and C changed only while resetN is low. */
`timescale 1ns/100ps
module rbms_strap_model (
    input logic mclk,
    input logic resetReq,
    input logic [3:0] strap,
    input logic flagTwoOut_r,
    input logic flagTwoOeN,
    output logic resetN,
    output logic modeA,
    output logic modeB,
    output logic modeD,
    output logic flagTwoIn
);
    logic floatLvl = 1'b0;
    initial resetN = 1'b0;
    always @(posedge mclk) begin
        resetN <= !resetReq;
        floatLvl <= !floatLvl;
    end
    assign modeA = strap[0];
    assign modeB = strap[1];
    assign modeD = strap[3];
    // No pull on the pin: a released line must not look stable
    assign flagTwoIn = !resetN ? strap[2] : (!flagTwoOeN ? flagTwoOut_r : floatLvl);
endmodule

// ==== dv/tb_rbms_core.sv ====
/* Testbench for rbms_core: boot modes, straps, registers, clock out.
   Assumes rbms_strap_model stands in for the board. */
`timescale 1ns/100ps
module tb_rbms_core;
    logic mclk = 1'b0, rst = 1'b1, resetReq = 1'b1, busReq = 1'b0, wordDone = 1'b0;
    logic pmWr = 1'b0, ackReq = 1'b0, regWr = 1'b0, regRd = 1'b0, a;
    logic [3:0] strap = 4'h0, regAddr = 4'h0, c;
    logic [13:0] pmAddr = 14'h0000;
    logic [15:0] regWdata = 16'h0000, rdv;
    logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'hc, 4'hd};
    wire resetN, modeA, modeB, modeD, flagTwoIn, flagTwoOut_r, flagTwoOeN, hostAckOut;
    wire hostAckOeN, byteDmaStart_r, coreHold_r, fetchExternal_r, hostMode_r;
    wire masterReset_r, cycleClockOut;
    wire [5:0] byteDmaWords;
    wire [13:0] firstFetchAddr_r;
    wire [15:0] regRdata_r;
    int mismatches = 0, checked = 0, n;
    rbms_core i_rbms_core (.mclk, .rst, .resetN, .modeA, .modeB, .modeD, .flagTwoIn,
        .flagTwoOut_r, .flagTwoOeN, .busReq, .byteDmaWordDone(wordDone), .hostPmWrite(pmWr),
        .hostPmAddr(pmAddr), .ackReq, .hostAckOut, .hostAckOeN, .byteDmaStart_r,
        .byteDmaWords, .coreHold_r, .fetchExternal_r, .firstFetchAddr_r, .hostMode_r,
        .masterReset_r, .cycleClockOut, .regAddr, .regWdata, .regWr, .regRd, .regRdata_r);
    rbms_strap_model i_rbms_strap_model (.mclk, .resetReq, .strap, .flagTwoOut_r,
        .flagTwoOeN, .resetN, .modeA, .modeB, .modeD, .flagTwoIn);
    always #4 mclk = ~mclk;
    always @(posedge mclk) ackReq <= ~ackReq;
    task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task wr(input logic [3:0] ad, input logic [15:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= ad;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [3:0] ad);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= ad;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rdv = regRdata_r;
    endtask
    task pulse(input logic hostW, input logic [13:0] ad);
        @(posedge mclk);
        wordDone <= !hostW;
        pmWr <= hostW;
        pmAddr <= ad;
        @(posedge mclk);
        wordDone <= 1'b0;
        pmWr <= 1'b0;
    endtask
    task complete_run;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(8 * 30000);
        mismatches++;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (4100) @(posedge mclk);
        busReq <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            c = codes[i];
            if (i > 0) begin
                @(posedge mclk);
                resetReq <= 1'b1;
                repeat (2) @(posedge mclk);
                strap <= c;
                rd(4'h3);
                chk(rdv[7:6], 2'b11, "stack and hold in reset");
                @(posedge mclk);
            end
            resetReq <= 1'b0;
            if (i == 0) begin
                repeat (12) begin
                    @(posedge mclk);
                    #1 chk({coreHold_r, byteDmaStart_r}, 2'b10, "boot under bus request");
                end
                @(posedge mclk);
                busReq <= 1'b0;
            end
            if (c[1]) begin
                repeat (6) @(posedge mclk);
                #1 chk({coreHold_r, fetchExternal_r}, 2'b01, "no-boot start");
            end else if (c[0]) begin
                repeat (6) @(posedge mclk);
                pulse(1'b1, 14'h0005);
                #1 chk(coreHold_r, 1'b1, "hold lost early");
                pulse(1'b1, 14'h0000);
                @(posedge mclk);
                #1 chk(coreHold_r, 1'b0, "host load hold");
            end else begin
                n = 0;
                while (byteDmaStart_r !== 1'b1 && n < 20) begin
                    @(posedge mclk);
                    #1 n++;
                end
                chk(byteDmaStart_r, 1'b1, "no byte boot");
                chk(byteDmaWords, 16'h0020, "boot word count");
                repeat (31) pulse(1'b0, 14'h0000);
                #1 chk(coreHold_r, 1'b1, "hold before word 32");
                pulse(1'b0, 14'h0000);
                @(posedge mclk);
                #1 chk({coreHold_r, fetchExternal_r}, 2'b00, "hold after word 32");
            end
            chk(hostMode_r, c[2], "memory mode");
            strap <= c ^ 4'h3;
            rd(4'h3);
            chk(rdv & 16'h00ff, {8'h00, 3'b001, c[2], c}, "status");
            strap <= c;
            rd(4'h1);
            chk(rdv, 16'h0000, "mode status");
            rd(4'h2);
            chk(rdv, 16'h0000, "mask");
            wr(4'h2, 16'h03ff);
            rd(4'h2);
            chk(rdv, 16'h03ff, "mask write");
            wr(4'h1, 16'h00ff);
            rd(4'h1);
            chk(rdv, 16'h007f, "mode status write");
            $display("test mode %h done", c);
        end
        rd(4'hf);
        chk(rdv, 16'h0000, "unmapped");
        wr(4'h0, 16'h4000);
        repeat (2) @(posedge mclk);
        #1 a = cycleClockOut;
        @(posedge mclk);
        #1 chk({a, cycleClockOut}, 2'b00, "clock out disabled");
        wr(4'h0, 16'h0000);
        @(posedge mclk);
        #1 a = cycleClockOut;
        @(posedge mclk);
        #1 chk(cycleClockOut ^ a, 1'b1, "clock out toggle");
        wr(4'h4, 16'h0001);
        wr(4'h5, 16'h0001);
        rd(4'h5);
        chk({flagTwoOeN, rdv[0]}, 2'b01, "flag output");
        $display("test registers done");
        complete_run;
    end
endmodule
